//--- hw/hdrv_core.sv
// haptic driver core: serial register port, bring-up gating, trigger playback, resonance tracking
// Functional notes
// - The resonance tracker locks after half a drive cycle and then follows back-EMF every half cycle.
// - Resonance tracking needs no calibration and is untouched by the level calibration.
// - Pin-only playback works with separate pins, both pins on one line, or both tied high.
// - If the supply is not good when the startup time ends, lockout is flagged and nothing plays.
// - A trigger-pin edge or level starts the loaded effect with no serial traffic.
// - With the trigger pin grounded, effects fired over the serial port work normally.
// - After reset the device is closed loop, real-time playback, level-sensitive trigger.
// - When playback ends the device returns to standby by itself.
`timescale 1ns/10ps
module hdrv_core #(
   parameter int         POWERUP_CYCLES = hdrv_pkg::HDRV_POWERUP_CYCLES,
   parameter int         STARTUP_CYCLES = hdrv_pkg::HDRV_STARTUP_CYCLES,
   parameter int         EFFECT_CYCLES  = hdrv_pkg::HDRV_EFFECT_CYCLES,
   parameter logic [6:0] DEV_ADDR       = hdrv_pkg::HDRV_DEV_ADDR
)(
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       clk_en_i,
   input  wire logic       shutdown_release_pin_i,
   input  wire logic       trigger_interrupt_pin_i,
   input  wire logic       supply_good_i,
   input  wire logic       bemf_sign_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic            drive_phase_o,
   output logic [7:0]      drive_amp_o,
   output logic            playing_o,
   output logic            standby_o,
   output logic            undervoltage_lockout_o
);
   import hdrv_pkg::*;
   localparam int CW = 20;

   logic [1:0] scl_sy, sda_sy, trig_sy, shdn_sy, sup_sy, bemf_sy;
   logic       scl_p, sda_p, trig_p, bemf_p;
   logic [CW-1:0] pw_cnt_reg, st_cnt_reg, eff_cnt_reg;
   logic       ready_reg, st_done_reg, undervoltage_lockout_reg;
   hdrv_i2c_state_type i_st_reg;
   logic [7:0] sh_reg, rd_reg, ptr_reg, wr_addr_reg, wr_data_reg;
   logic [3:0] bit_reg;
   logic       rw_reg, wr_stb_reg, oe_reg;
   logic [7:0] mode_reg, rtp_reg, level_reg;
   logic       lib_reg, cal_busy_reg, calibrated_reg;
   logic [10:0] cal_cnt_reg;
   logic [7:0] cal_zc_reg;
   logic       play_reg, src_pin_reg, armed_reg, standby_reg;
   logic [15:0] half_cnt_reg, half_period_reg, ol_cnt_reg;
   logic       seen_reg, locked_reg, phase_reg;
   logic [7:0] amp_reg;

   // every asynchronous pin passes two flip-flops; only stage 1 is read
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         {scl_sy, sda_sy, trig_sy, shdn_sy, sup_sy, bemf_sy} <= 12'h000;
         {scl_p, sda_p, trig_p, bemf_p} <= 4'h0;
      end
      else if (clk_en_i)
      begin
         scl_sy  <= {scl_sy[0], scl_i};
         sda_sy  <= {sda_sy[0], sda_i};
         trig_sy <= {trig_sy[0], trigger_interrupt_pin_i};
         shdn_sy <= {shdn_sy[0], shutdown_release_pin_i};
         sup_sy  <= {sup_sy[0], supply_good_i};
         bemf_sy <= {bemf_sy[0], bemf_sign_i};
         {scl_p, sda_p, trig_p, bemf_p} <= {scl_sy[1], sda_sy[1], trig_sy[1], bemf_sy[1]};
      end
   end

   logic scl_rise, scl_fall, i_start, i_stop, trig_rise, trig_fall, bemf_zc, en;
   assign scl_rise  = scl_sy[1] & ~scl_p;
   assign scl_fall  = ~scl_sy[1] & scl_p;
   assign i_start   = scl_sy[1] & scl_p & sda_p & ~sda_sy[1];
   assign i_stop    = scl_sy[1] & scl_p & ~sda_p & sda_sy[1];
   assign trig_rise = trig_sy[1] & ~trig_p;
   assign trig_fall = ~trig_sy[1] & trig_p;
   assign bemf_zc   = bemf_sy[1] ^ bemf_p;
   // playing needs release pin high, startup done and no lockout
   assign en = shdn_sy[1] & st_done_reg & ~undervoltage_lockout_reg;

   // power-up wait; the serial port stays deaf until it ends
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         pw_cnt_reg <= '0;
         ready_reg  <= 1'b0;
      end
      else if (clk_en_i && !ready_reg)
      begin
         pw_cnt_reg <= pw_cnt_reg + 1'b1;
         ready_reg  <= (pw_cnt_reg == CW'(POWERUP_CYCLES - 1));
      end
   end

   // startup window; a supply still low at its end means a slow ramp
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         st_cnt_reg  <= '0;
         st_done_reg <= 1'b0;
         undervoltage_lockout_reg    <= 1'b0;
      end
      else if (clk_en_i && !st_done_reg)
      begin
         st_cnt_reg <= st_cnt_reg + 1'b1;
         if (st_cnt_reg == CW'(STARTUP_CYCLES - 1))
         begin
            st_done_reg <= 1'b1;
            undervoltage_lockout_reg    <= ~sup_sy[1];
         end
      end
   end

   // register read view; unmapped offsets read zero
   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         HDRV_ADDR_STATUS: v = {2'h0, locked_reg, calibrated_reg, cal_busy_reg, undervoltage_lockout_reg,
                                standby_reg, play_reg};
         HDRV_ADDR_MODE:   v = mode_reg;
         HDRV_ADDR_CTRL:   v = {5'h00, lib_reg, cal_busy_reg, play_reg};
         HDRV_ADDR_RTP:    v = rtp_reg;
         HDRV_ADDR_LEVEL:  v = level_reg;
         HDRV_ADDR_RESON:  v = half_period_reg[15:8];
         default:          v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // serial slave; shifts on scl rise, moves on scl fall, pointer auto-increments
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         i_st_reg <= HDRV_I_IDLE;
         {sh_reg, rd_reg, ptr_reg, wr_addr_reg, wr_data_reg} <= 40'h00_0000_0000;
         bit_reg <= 4'h0;
         rw_reg  <= 1'b0;
         wr_stb_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         wr_stb_reg <= 1'b0;
         if (i_stop)
            i_st_reg <= HDRV_I_IDLE;
         else if (i_start)
         begin
            i_st_reg <= HDRV_I_ADDR;
            bit_reg  <= 4'h0;
         end
         else
         begin
            unique case (i_st_reg)
               HDRV_I_IDLE: ;
               HDRV_I_ADDR, HDRV_I_REG, HDRV_I_WDAT:
               begin
                  if (scl_rise)
                  begin
                     sh_reg  <= {sh_reg[6:0], sda_sy[1]};
                     bit_reg <= bit_reg + 4'h1;
                  end
                  else if (scl_fall && bit_reg == 4'h8)
                  begin
                     bit_reg <= 4'h0;
                     if (i_st_reg == HDRV_I_ADDR)
                     begin
                        rw_reg <= sh_reg[0];
                        // no acknowledge before the wait ends
                        i_st_reg <= (ready_reg && sh_reg[7:1] == DEV_ADDR) ?
                                    HDRV_I_AACK : HDRV_I_IDLE;
                     end
                     else if (i_st_reg == HDRV_I_REG)
                     begin
                        ptr_reg  <= sh_reg;
                        i_st_reg <= HDRV_I_RACK;
                     end
                     else
                     begin
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= sh_reg;
                        wr_stb_reg  <= 1'b1;
                        i_st_reg    <= HDRV_I_WACK;
                     end
                  end
               end
               HDRV_I_AACK:
                  if (scl_fall)
                  begin
                     rd_reg   <= rd_mux(ptr_reg);
                     i_st_reg <= rw_reg ? HDRV_I_RDAT : HDRV_I_REG;
                  end
               HDRV_I_RACK:
                  if (scl_fall)
                     i_st_reg <= HDRV_I_WDAT;
               HDRV_I_WACK:
                  if (scl_fall)
                  begin
                     ptr_reg  <= ptr_reg + 8'h01;
                     i_st_reg <= HDRV_I_WDAT;
                  end
               HDRV_I_RDAT:
                  if (scl_rise)
                     bit_reg <= bit_reg + 4'h1;
                  else if (scl_fall)
                  begin
                     if (bit_reg == 4'h8)
                     begin
                        bit_reg  <= 4'h0;
                        i_st_reg <= HDRV_I_MACK;
                     end
                     else
                        rd_reg <= {rd_reg[6:0], 1'b0};
                  end
               HDRV_I_MACK:
                  if (scl_rise)
                     rw_reg <= ~sda_sy[1];  // master ack keeps reading
                  else if (scl_fall)
                  begin
                     ptr_reg  <= ptr_reg + 8'h01;
                     rd_reg   <= rd_mux(ptr_reg + 8'h01);
                     i_st_reg <= rw_reg ? HDRV_I_RDAT : HDRV_I_IDLE;
                  end
               default: i_st_reg <= HDRV_I_IDLE;
            endcase
         end
      end
   end

   // open-drain data line: enable pulls low, registered to change while scl is low
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         oe_reg <= 1'b0;
      else if (clk_en_i)
         oe_reg <= (i_st_reg == HDRV_I_AACK) || (i_st_reg == HDRV_I_RACK) ||
                   (i_st_reg == HDRV_I_WACK) || (i_st_reg == HDRV_I_RDAT && !rd_reg[7]);
   end

   logic mode_wr, ctrl_wr, pin_start, start, stop, rom, edge_mode;
   assign mode_wr   = wr_stb_reg && wr_addr_reg == HDRV_ADDR_MODE;
   assign ctrl_wr   = wr_stb_reg && wr_addr_reg == HDRV_ADDR_CTRL;
   assign rom       = mode_reg[HDRV_MODE_SRC_LSB +: 2] == HDRV_SRC_ROM;
   assign edge_mode = mode_reg[HDRV_MODE_EDGE_BIT];
   // level mode plays once per high level, so a pin tied high plays once
   assign pin_start = edge_mode ? trig_rise : (trig_sy[1] & armed_reg);
   assign start = en && !play_reg && !cal_busy_reg &&
                  ((ctrl_wr && wr_data_reg[HDRV_CTRL_GO_BIT]) || pin_start);
   assign stop  = play_reg && (!en || (ctrl_wr && !wr_data_reg[HDRV_CTRL_GO_BIT]) ||
                  (src_pin_reg && !edge_mode && trig_fall) || (edge_mode && trig_rise) ||
                  (rom && eff_cnt_reg == CW'(EFFECT_CYCLES - 1)));

   // configuration registers written by the host
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_reg <= HDRV_MODE_RESET;
         rtp_reg  <= HDRV_RTP_RESET;
         lib_reg  <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (mode_wr)
            mode_reg <= wr_data_reg;
         if (wr_stb_reg && wr_addr_reg == HDRV_ADDR_RTP)
            rtp_reg <= wr_data_reg;
         if (ctrl_wr)
            lib_reg <= wr_data_reg[HDRV_CTRL_LIB_BIT];
      end
   end

   // playback and standby; a grounded trigger never blocks serial go
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         play_reg    <= 1'b0;
         src_pin_reg <= 1'b0;
         armed_reg   <= 1'b1;
         standby_reg <= 1'b1;
         eff_cnt_reg <= '0;
      end
      else if (clk_en_i)
      begin
         eff_cnt_reg <= play_reg ? eff_cnt_reg + 1'b1 : '0;
         if (!trig_sy[1])
            armed_reg <= 1'b1;
         if (stop)
         begin
            play_reg    <= 1'b0;
            standby_reg <= 1'b1;
         end
         else if (start)
         begin
            play_reg    <= 1'b1;
            standby_reg <= 1'b0;
            src_pin_reg <= pin_start && !(ctrl_wr && wr_data_reg[HDRV_CTRL_GO_BIT]);
            armed_reg   <= 1'b0;
         end
         else if (mode_wr)
            standby_reg <= 1'b0;
      end
   end

   // level calibration counts back-EMF crossings; it never touches the tracker
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         level_reg      <= HDRV_LEVEL_RESET;
         cal_busy_reg   <= 1'b0;
         calibrated_reg <= 1'b0;
         cal_cnt_reg    <= 11'h000;
         cal_zc_reg     <= 8'h00;
      end
      else if (clk_en_i)
      begin
         if (cal_busy_reg)
         begin
            cal_cnt_reg <= cal_cnt_reg + 11'h001;
            if (bemf_zc && cal_zc_reg != 8'hff)
               cal_zc_reg <= cal_zc_reg + 8'h01;
            if (cal_cnt_reg == 11'(HDRV_CAL_CYCLES - 1))
            begin
               cal_busy_reg   <= 1'b0;
               calibrated_reg <= 1'b1;
               level_reg      <= cal_zc_reg;
            end
         end
         else if (ctrl_wr && wr_data_reg[HDRV_CTRL_CAL_BIT] && en && !play_reg)
         begin
            cal_busy_reg <= 1'b1;
            cal_cnt_reg  <= 11'h000;
            cal_zc_reg   <= 8'h00;
         end
         else if (wr_stb_reg && wr_addr_reg == HDRV_ADDR_LEVEL)
         begin
            level_reg      <= wr_data_reg;  // restored earlier result
            calibrated_reg <= 1'b1;
         end
      end
   end

   // resonance tracker: lock on the second crossing, then refresh every half cycle
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         {half_cnt_reg, half_period_reg, ol_cnt_reg} <= 48'h0000_0000_0000;
         {seen_reg, locked_reg, phase_reg} <= 3'h0;
         amp_reg <= 8'h00;
      end
      else if (clk_en_i)
      begin
         amp_reg <= play_reg ? (rom ? level_reg : rtp_reg) : 8'h00;
         if (!play_reg)
         begin
            {half_cnt_reg, ol_cnt_reg} <= 32'h0000_0000;
            {seen_reg, locked_reg} <= 2'h0;
         end
         else
         begin
            half_cnt_reg <= (half_cnt_reg == 16'hffff) ? half_cnt_reg : half_cnt_reg + 16'h0001;
            ol_cnt_reg   <= ol_cnt_reg + 16'h0001;
            if (bemf_zc)
            begin
               half_cnt_reg <= 16'h0000;
               seen_reg     <= 1'b1;
               if (seen_reg)
               begin
                  half_period_reg <= half_cnt_reg + 16'h0001;
                  locked_reg      <= 1'b1;
               end
            end
            // open loop runs a fixed half period, closed loop follows back-EMF
            if (mode_reg[HDRV_MODE_OPEN_BIT])
            begin
               if (ol_cnt_reg == 16'(HDRV_OL_HALF_CYCLES - 1))
               begin
                  ol_cnt_reg <= 16'h0000;
                  phase_reg  <= ~phase_reg;
               end
            end
            else if (bemf_zc)
               phase_reg <= ~phase_reg;
         end
      end
   end

   assign sda_o                  = 1'b0;
   assign sda_oe_o               = oe_reg;
   assign drive_phase_o          = phase_reg;
   assign drive_amp_o            = amp_reg;
   assign playing_o              = play_reg;
   assign standby_o              = standby_reg;
   assign undervoltage_lockout_o = undervoltage_lockout_reg;

   // checks
   property p_reset_state;
      @(posedge core_clk_i) $fell(sys_rst_i) |-> mode_reg == 8'h00 && standby_reg && !play_reg;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_lock;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      clk_en_i && play_reg && !stop && seen_reg && bemf_zc |=> locked_reg &&
      half_period_reg == $past(half_cnt_reg) + 16'h0001;
   endproperty
   a_lock: assert property (p_lock) else $error("tracker did not lock");
   property p_cal_indep;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      cal_busy_reg && !play_reg ##1 cal_busy_reg |-> $stable(half_period_reg);
   endproperty
   a_cal_indep: assert property (p_cal_indep) else $error("calibration moved tracker");
   property p_pin_start;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      clk_en_i && en && !play_reg && !cal_busy_reg && !edge_mode && trig_sy[1] && armed_reg
      |=> play_reg && !standby_reg;
   endproperty
   a_pin_start: assert property (p_pin_start) else $error("pin did not start");
   property p_undervoltage_lockout_block;
      @(posedge core_clk_i) disable iff (sys_rst_i) undervoltage_lockout_reg |-> !play_reg && !start;
   endproperty
   a_undervoltage_lockout_block: assert property (p_undervoltage_lockout_block) else $error("played under lockout");
   property p_undervoltage_lockout_set;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      clk_en_i && !st_done_reg && st_cnt_reg == CW'(STARTUP_CYCLES - 1) && !sup_sy[1]
      |=> undervoltage_lockout_reg ##1 undervoltage_lockout_reg;
   endproperty
   a_undervoltage_lockout_set: assert property (p_undervoltage_lockout_set) else $error("lockout not flagged");
   property p_go_trig_low;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      clk_en_i && !trig_sy[1] && start |=> play_reg ##1 (play_reg || $past(stop));
   endproperty
   a_go_trig_low: assert property (p_go_trig_low) else $error("grounded trigger broke go");
   property p_standby_end;
      @(posedge core_clk_i) disable iff (sys_rst_i) $fell(play_reg) |-> standby_reg && standby_o;
   endproperty
   a_standby_end: assert property (p_standby_end) else $error("no standby after play");
   property p_early_write;
      @(posedge core_clk_i) disable iff (sys_rst_i) wr_stb_reg |-> ready_reg;
   endproperty
   a_early_write: assert property (p_early_write) else $error("write before wait");
   property p_tied_high;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(en) && trig_sy[1] && armed_reg && !edge_mode && !cal_busy_reg && clk_en_i
      |=> play_reg;
   endproperty
   a_tied_high: assert property (p_tied_high) else $error("tied pins did not play");
   c_pin_play: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(play_reg) && src_pin_reg);
   c_go_play: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(play_reg) && !src_pin_reg);
   c_locked: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(locked_reg));
   c_cal_done: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(cal_busy_reg));
endmodule : hdrv_core

//--- hw/hdrv_pkg.sv
// package of register map, field positions, reset values and timing for the haptic driver core
package hdrv_pkg;
   // register byte offsets reached through the two-wire serial port
   localparam logic [7:0] HDRV_ADDR_STATUS = 8'h00;
   localparam logic [7:0] HDRV_ADDR_MODE   = 8'h01;
   localparam logic [7:0] HDRV_ADDR_CTRL   = 8'h02;
   localparam logic [7:0] HDRV_ADDR_RTP    = 8'h03;
   localparam logic [7:0] HDRV_ADDR_LEVEL  = 8'h04;
   localparam logic [7:0] HDRV_ADDR_RESON  = 8'h05;
   // field positions
   localparam int HDRV_MODE_SRC_LSB   = 0;
   localparam int HDRV_MODE_EDGE_BIT  = 2;
   localparam int HDRV_MODE_OPEN_BIT  = 3;
   localparam int HDRV_CTRL_GO_BIT    = 0;
   localparam int HDRV_CTRL_CAL_BIT   = 1;
   localparam int HDRV_CTRL_LIB_BIT   = 2;
   // playback sources in the mode field
   localparam logic [1:0] HDRV_SRC_RTP = 2'h0;
   localparam logic [1:0] HDRV_SRC_ROM = 2'h1;
   // values after reset
   localparam logic [7:0] HDRV_MODE_RESET  = 8'h00;
   localparam logic [7:0] HDRV_RTP_RESET   = 8'h00;
   localparam logic [7:0] HDRV_LEVEL_RESET = 8'h80;
   localparam logic [6:0] HDRV_DEV_ADDR    = 7'h48;  // arbitrary bus address
   // timing at the 250 MHz core clock
   localparam int HDRV_CLK_MHZ          = 250;
   localparam int HDRV_POWERUP_WAIT_MS  = 1;
   localparam int HDRV_POWERUP_CYCLES   = HDRV_POWERUP_WAIT_MS * 1000 * HDRV_CLK_MHZ;
   localparam int HDRV_STARTUP_US       = 500;
   localparam int HDRV_STARTUP_CYCLES   = HDRV_STARTUP_US * HDRV_CLK_MHZ;
   localparam int HDRV_EFFECT_US        = 1000;
   localparam int HDRV_EFFECT_CYCLES    = HDRV_EFFECT_US * HDRV_CLK_MHZ;
   localparam int HDRV_CAL_CYCLES       = 1024;
   localparam int HDRV_OL_HALF_CYCLES   = 1024;
   // serial port states, one-hot
   typedef enum logic [8:0] {
      HDRV_I_IDLE = 9'h001,
      HDRV_I_ADDR = 9'h002,
      HDRV_I_AACK = 9'h004,
      HDRV_I_REG  = 9'h008,
      HDRV_I_RACK = 9'h010,
      HDRV_I_WDAT = 9'h020,
      HDRV_I_WACK = 9'h040,
      HDRV_I_RDAT = 9'h080,
      HDRV_I_MACK = 9'h100
   } hdrv_i2c_state_type;
endpackage : hdrv_pkg

//--- verification/hdrv_core_tb.sv
// self-checking bench for bring-up, trigger, calibration and playback of the haptic core
`timescale 1ns/10ps
module hdrv_core_tb;
   import hdrv_pkg::*;
   localparam int PWR = 400;
   localparam int EFF = 200;
   logic       core_clk_i = 1'b0;
   logic       sys_rst_i  = 1'b1;
   logic       rel        = 1'b0;
   logic       trig       = 1'b0;
   logic       good       = 1'b1;
   logic       bemf       = 1'b0;
   logic       scl, sda, oe, play, stby, lock, ok;
   logic [7:0] amp, rv;
   int         errors     = 0;
   int         compares   = 0;
   int         cycles     = 0;
   hdrv_core #(.POWERUP_CYCLES(PWR), .STARTUP_CYCLES(32), .EFFECT_CYCLES(EFF)) u_dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
      .shutdown_release_pin_i(rel), .trigger_interrupt_pin_i(trig), .supply_good_i(good),
      .bemf_sign_i(bemf), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
      .drive_phase_o(), .drive_amp_o(amp), .playing_o(play), .standby_o(stby),
      .undervoltage_lockout_o(lock));
   hdrv_host_model u_host (.core_clk_i(core_clk_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
   initial forever #2 core_clk_i = ~core_clk_i;
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      u_host.xact(1'b0, a, v, rv, ok);
      chk({7'h00, ok}, 8'h01);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      u_host.xact(1'b1, a, 8'h00, rv, ok);
      chk(rv & m, e);
   endtask : rd
   // early access is refused, then wait, release, mode write in order
   task automatic t_bringup();
      u_host.xact(1'b0, HDRV_ADDR_MODE, 8'h00, rv, ok);
      chk({4'h0, ok, stby, play, lock}, 8'h04);
      rel = 1'b1;
      // the refused access above already outlasts the wait, so this one is legal
      rd(HDRV_ADDR_MODE, 8'hff, HDRV_MODE_RESET);
      rd(HDRV_ADDR_LEVEL, 8'hff, HDRV_LEVEL_RESET);
      wr(HDRV_ADDR_MODE, 8'h00);
      chk({7'h00, stby}, 8'h00);
   endtask : t_bringup
   // pin-started and serial-started playback, both falling back to standby
   task automatic t_play();
      wr(HDRV_ADDR_RTP, 8'h5a);
      trig = 1'b1;
      step(6);
      chk({6'h00, play, stby}, 8'h02);
      chk(amp, 8'h5a);
      trig = 1'b0;
      step(6);
      chk({6'h00, play, stby}, 8'h01);
      wr(HDRV_ADDR_MODE, 8'h00);
      wr(HDRV_ADDR_CTRL, 8'h01);
      chk({7'h00, play}, 8'h01);
      // two crossings while playing are enough for the tracker to lock
      repeat (3)
      begin
         step(20);
         bemf = ~bemf;
      end
      rd(HDRV_ADDR_STATUS, 8'h20, 8'h20);
      wr(HDRV_ADDR_CTRL, 8'h00);
      chk({6'h00, play, stby}, 8'h01);
   endtask : t_play
   // ten crossings during calibration; tracker must stay unlocked
   task automatic t_cal();
      wr(HDRV_ADDR_CTRL, 8'h02);
      repeat (10)
      begin
         step(20);
         bemf = ~bemf;
      end
      step(1100);
      rd(HDRV_ADDR_STATUS, 8'h3c, 8'h10);
      rd(HDRV_ADDR_LEVEL, 8'hff, 8'h0a);
   endtask : t_cal
   // rom effect plays at the calibrated level and ends by itself
   task automatic t_rom();
      wr(HDRV_ADDR_CTRL, 8'h04);
      rd(HDRV_ADDR_CTRL, 8'h04, 8'h04);
      wr(HDRV_ADDR_MODE, 8'h01);
      wr(HDRV_ADDR_CTRL, 8'h05);
      chk(amp, 8'h0a);
      step(EFF);
      chk({6'h00, play, stby}, 8'h01);
   endtask : t_rom
   // one shared line, pins tied high, then tied high with a slow supply
   task automatic t_pins();
      for (int k = 0; k < 3; k++)
      begin
         good = (k != 2);
         rel = (k != 0);
         trig = (k != 0);
         sys_rst_i = 1'b1;
         step(2);
         sys_rst_i = 1'b0;
         rel = 1'b1;
         trig = 1'b1;
         step(60);
         chk({6'h00, play, lock}, (k == 2) ? 8'h01 : 8'h02);
      end
   endtask : t_pins
   task automatic stop_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // watchdog: the run needs about 15000 cycles
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         stop_test();
      end
   end
   initial
   begin
      step(2);
      sys_rst_i = 1'b0;
      t_bringup();
      t_play();
      t_cal();
      t_rom();
      t_pins();
      stop_test();
   end
endmodule : hdrv_core_tb

//--- verification/hdrv_host_model.sv
// host model: two-wire serial master and pulled-up data wire for the haptic driver core
`timescale 1ns/10ps
module hdrv_host_model (
   input  wire logic core_clk_i,
   input  wire logic sda_oe_i,
   output logic      scl_o,
   output logic      sda_o
);
   import hdrv_pkg::*;
   logic drv_reg = 1'b1;
   initial scl_o = 1'b1;
   // pull-up wins unless a party pulls low
   assign sda_o = drv_reg & ~sda_oe_i;
   // one phase of 8 cycles, twice the minimum, so the synced pins settle
   task automatic pin(input logic c, input logic d);
      scl_o = c;
      drv_reg = d;
      repeat (8) @(posedge core_clk_i);
      #1;
   endtask : pin
   // only one line moves per phase, so no false start or stop is seen
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         pin(1'b0, drv_reg);
         pin(1'b0, d[i]);
         pin(1'b1, d[i]);
         q[i] = sda_o;
      end
   endtask : xfer
   // write: addr, pointer, data; read: addr, pointer, restart, addr, data with nack
   task automatic xact(input logic rd, input logic [7:0] a, input logic [7:0] v,
                       output logic [7:0] r, output logic ok);
      logic [8:0] q1, q2, q3;
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
      xfer({HDRV_DEV_ADDR, 2'b01}, q1);
      xfer({a, 1'b1}, q2);
      if (rd)
      begin
         pin(1'b0, 1'b1);
         pin(1'b1, 1'b1);
         pin(1'b1, 1'b0);
         xfer({HDRV_DEV_ADDR, 2'b11}, q3);
      end
      xfer(rd ? 9'h1ff : {v, 1'b1}, q3);
      pin(1'b0, drv_reg);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      pin(1'b1, 1'b1);
      ok = ~(q1[0] | q2[0]);
      r = q3[8:1];
   endtask : xact
endmodule : hdrv_host_model
